// File: rtl/tss_pkg.sv
package tss_pkg;
  // ==========================================================================
  // Word layout
  localparam int WORD_W = 16;
  localparam int TEMP_W = 14;
  localparam int RX_W = 8;
  localparam int MAKER_W = 5;
  localparam int DEVICE_W = TEMP_W - MAKER_W;
  localparam logic [1:0] FILL_BITS = 2'h3;
  localparam int TEMP_LSB_UDEGC = 31250;
  // ==========================================================================
  // Frame timing, in serial clocks
  localparam int TX_CLKS = 16;
  localparam int FRAME_CLKS = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] TX_LAST = CNT_W'(TX_CLKS);
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_CLKS);
  localparam logic [3:0] RX_FULL = 4'(RX_W);
  // ==========================================================================
  // Commands and reset values
  localparam logic [RX_W-1:0] CMD_SHUTDOWN = 8'hFF;
  localparam logic [RX_W-1:0] CMD_CONTINUOUS = 8'h00;
  localparam logic SHUTDOWN_RST = 1'b0;
  localparam logic [TEMP_W-1:0] TEMP_RST = 14'h0000;
  // Arbitrary identification values
  localparam logic [MAKER_W-1:0] MAKER_ID_DEF = 5'h0B;
  localparam logic [DEVICE_W-1:0] DEVICE_ID_DEF = 9'h055;
  // ==========================================================================
  // Frame states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TX = 3'b010,
    ST_RX = 3'b100
  } tss_state_e;
endpackage : tss_pkg

// File: rtl/tss_sync.sv
`timescale 1ns/1ns
module tss_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // ==========================================================================
  // Two stages; the first is read by the second only
  logic [W-1:0] meta_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : tss_sync

// File: rtl/tss_top.sv
`timescale 1ns/1ns
module tss_top
  import tss_pkg::*;
#(
  parameter logic [MAKER_W-1:0] MAKER_ID = MAKER_ID_DEF,
  parameter logic [DEVICE_W-1:0] DEVICE_ID = DEVICE_ID_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic serial_bit_clock,
  input wire logic sio_in,
  output logic sio_out,
  output logic sio_oe,
  input wire logic [TEMP_W-1:0] conv_data,
  input wire logic conv_done,
  output logic conv_enable,
  output logic shutdown
);
  // ==========================================================================
  // Pin synchronisers
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  tss_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in({cs_n, serial_bit_clock, sio_in}),
    .sync_out(pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // ==========================================================================
  // Edge detection
  logic cs_prev_r;
  logic sck_prev_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cs_prev_r <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      cs_prev_r <= cs_n_s;
      sck_prev_r <= sck_s;
    end
  end
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall = cs_prev_r & ~cs_n_s;
  assign cs_rise = ~cs_prev_r & cs_n_s;
  assign sck_rise = ~cs_n_s & ~sck_prev_r & sck_s;
  assign sck_fall = ~cs_n_s & sck_prev_r & ~sck_s;

  // ==========================================================================
  // Frame state and clock count
  tss_state_e state_r;
  tss_state_e state_nxt;
  logic [CNT_W-1:0] rise_cnt_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = ST_TX;
        end
      end
      ST_TX: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end else if (sck_rise && rise_cnt_r == TX_LAST - 1'b1) begin
          state_nxt = ST_RX;
        end
      end
      ST_RX: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  // Count saturates so clocks past the frame are ignored
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rise_cnt_r <= '0;
    end else if (cs_fall) begin
      rise_cnt_r <= '0;
    end else if (sck_rise && rise_cnt_r != FRAME_LAST) begin
      rise_cnt_r <= rise_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Temperature holding with deferred update
  logic [TEMP_W-1:0] temp_r;
  logic [TEMP_W-1:0] pend_data_r;
  logic pend_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      temp_r <= TEMP_RST;
      pend_data_r <= TEMP_RST;
      pend_r <= 1'b0;
    end else if (conv_done && !cs_n_s) begin
      pend_data_r <= conv_data;
      pend_r <= 1'b1;
    end else if (conv_done) begin
      temp_r <= conv_data;
      pend_r <= 1'b0;
    end else if (pend_r && cs_n_s) begin
      temp_r <= pend_data_r;
      pend_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Output shift register
  // No write path reaches the read-only words
  logic [WORD_W-1:0] temp_word;
  logic [WORD_W-1:0] id_word;
  logic [WORD_W-1:0] sh_r;
  logic shutdown_r;
  assign temp_word = {temp_r, FILL_BITS};
  assign id_word = {MAKER_ID, DEVICE_ID, FILL_BITS};
  // Shifting needs a prior rising edge so an idle-high clock keeps the leading bit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sh_r <= '1;
    end else if (cs_fall) begin
      sh_r <= shutdown_r ? id_word : temp_word;
    end else if (sck_fall && state_r == ST_TX && rise_cnt_r != '0) begin
      sh_r <= {sh_r[WORD_W-2:0], 1'b1};
    end
  end
  assign sio_out = sh_r[WORD_W-1];
  // Early release needs nothing more; the word is whole at every bit
  assign sio_oe = (state_r == ST_TX);

  // ==========================================================================
  // Input shift register and command decode
  logic [RX_W-1:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
    end else if (cs_fall) begin
      rx_cnt_r <= '0;
    end else if (sck_rise && state_r == ST_RX && rise_cnt_r != FRAME_LAST) begin
      rx_sh_r <= {rx_sh_r[RX_W-2:0], sdi_s};
      if (rx_cnt_r != RX_FULL) begin
        rx_cnt_r <= rx_cnt_r + 1'b1;
      end
    end
  end
  // Decode runs in either mode; unknown codes leave the mode alone
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shutdown_r <= SHUTDOWN_RST;
    end else if (cs_rise && rx_cnt_r == RX_FULL) begin
      if (rx_sh_r == CMD_SHUTDOWN) begin
        shutdown_r <= 1'b1;
      end else if (rx_sh_r == CMD_CONTINUOUS) begin
        shutdown_r <= 1'b0;
      end
    end
  end
  assign shutdown = shutdown_r;
  assign conv_enable = ~shutdown_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_fill_bits: assert property (cs_fall |=> sh_r[1:0] == FILL_BITS)
    else $error("fill bits not one after load");
  chk_shutdown_id: assert property (cs_fall && shutdown_r |=> sh_r == id_word)
    else $error("identification word not loaded in shutdown");
  chk_temp_load: assert property (cs_fall && !shutdown_r |=> sh_r == {$past(temp_r), FILL_BITS})
    else $error("temperature word not loaded");
  chk_msb_first: assert property (sck_fall && state_r == ST_TX && rise_cnt_r != '0
    |=> sio_out == $past(sh_r[WORD_W-2]))
    else $error("next bit not presented after falling edge");
  chk_enter_shutdown: assert property (cs_rise && rx_cnt_r == RX_FULL && rx_sh_r == CMD_SHUTDOWN
    |=> shutdown_r && !conv_enable)
    else $error("shutdown command not taken");
  chk_resume_conv: assert property (cs_rise && rx_cnt_r == RX_FULL && rx_sh_r == CMD_CONTINUOUS
    |=> !shutdown_r && conv_enable)
    else $error("continuous command not taken");
  chk_odd_code: assert property (cs_rise && rx_sh_r != CMD_SHUTDOWN && rx_sh_r != CMD_CONTINUOUS
    |=> $stable(shutdown_r))
    else $error("mode changed on undefined code");
  chk_partial_read: assert property (cs_rise && rx_cnt_r != RX_FULL |=> $stable(shutdown_r))
    else $error("mode changed on short frame");
  chk_defer_update: assert property (!cs_n_s && !$past(cs_n_s) |-> $stable(temp_r))
    else $error("temperature changed under low select");
  chk_rx_release: assert property (rise_cnt_r >= TX_LAST |-> !sio_oe)
    else $error("line driven in receive phase");
  chk_pending_apply: assert property (pend_r && cs_n_s && !conv_done |=> temp_r == $past(pend_data_r))
    else $error("pending temperature not applied");
  chk_pend_capture: assert property (conv_done && !cs_n_s
    |=> pend_r && pend_data_r == $past(conv_data))
    else $error("result under low select not held pending");
  // Driving stops on select rise so the host owns the line between frames
  chk_line_driven: assert property (cs_fall |=> sio_oe)
    else $error("line not driven after select fell");
  chk_select_release: assert property (cs_rise |=> !sio_oe)
    else $error("line still driven after select rose");
  chk_rx_shift: assert property (sck_rise && state_r == ST_RX && rise_cnt_r != FRAME_LAST
    |=> rx_sh_r[0] == $past(sdi_s))
    else $error("received bit not shifted in");
endmodule : tss_top

// File: verif/tss_host.sv
`timescale 1ns/1ns
module tss_host (
  input wire logic ref_clk,
  input wire logic line,
  output logic cs_n,
  output logic serial_bit_clock,
  output logic host_oe,
  output logic host_bit
);
  // ==========================================================================
  // Idle levels: select high, clock still and low
  initial begin
    cs_n = 1'b1;
    serial_bit_clock = 1'b0;
    host_oe = 1'b0;
    host_bit = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk
  // ==========================================================================
  // Frame: read bits, then write bits, then select high
  task automatic xfer(input logic [15:0] wr, input int n_rd, input int n_wr, output logic [15:0] rd);
    rd = 16'h0000;
    wait_clk(1);
    cs_n <= 1'b0;
    wait_clk(8);
    for (int i = 0; i < n_rd; i++) begin
      // Sampled before this edge lands; bit settled at least 1 cycle earlier
      rd[15 - i] = line;
      serial_bit_clock <= 1'b1;
      wait_clk(4);
      serial_bit_clock <= 1'b0;
      wait_clk(4);
    end
    for (int i = 0; i < n_wr; i++) begin
      // Bench only sends 00 or FF low bytes
      host_oe <= 1'b1;
      host_bit <= wr[n_wr - 1 - i];
      wait_clk(4);
      serial_bit_clock <= 1'b1;
      wait_clk(4);
      serial_bit_clock <= 1'b0;
    end
    wait_clk(4);
    cs_n <= 1'b1;
    host_oe <= 1'b0;
    wait_clk(8);
  endtask : xfer
endmodule : tss_host

// File: verif/test_tss_top.sv
`timescale 1ns/1ns
module test_tss_top;
  import tss_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [TEMP_W-1:0] conv_data = 14'h0000;
  logic conv_done = 1'b0;
  logic cs_n, serial_bit_clock, host_oe, host_bit, sio_out, sio_oe, conv_enable, shutdown, sio_in;
  logic line_last = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] rd;
  logic [15:0] id_word;
  logic [15:0] temps [5] = '{16'h4B03, 16'h0C83, 16'hFFFF, 16'h0007, 16'hEC03};
  always #25 ref_clk = ~ref_clk;
  // ==========================================================================
  // Shared line; undriven it toggles so stale bits never look valid
  assign sio_in = sio_oe ? sio_out : (host_oe ? host_bit : ~line_last);
  always @(posedge ref_clk) line_last <= sio_in;
  tss_top i_tss_top (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .serial_bit_clock(serial_bit_clock),
    .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .conv_data(conv_data), .conv_done(conv_done),
    .conv_enable(conv_enable), .shutdown(shutdown));
  tss_host i_tss_host (.ref_clk(ref_clk), .line(sio_in), .cs_n(cs_n), .serial_bit_clock(serial_bit_clock),
    .host_oe(host_oe), .host_bit(host_bit));
  // ==========================================================================
  // Checking and closing
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic mode_is(input logic sd);
    check("shutdown", {15'h0000, sd}, {15'h0000, shutdown});
    check("conv_enable", {15'h0000, ~sd}, {15'h0000, conv_enable});
    check("sio_oe", 16'h0000, {15'h0000, sio_oe});
  endtask : mode_is
  task automatic convert(input logic [15:0] w);
    @(posedge ref_clk);
    conv_data <= w[15:2];
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : convert
  // ==========================================================================
  // Main sequence
  initial begin
    id_word = {MAKER_ID_DEF, DEVICE_ID_DEF, 2'b11};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    mode_is(1'b0);
    i_tss_host.xfer(16'h0000, 16, 16, rd);
    check("reset word", 16'h0003, rd);
    foreach (temps[i]) begin
      convert(temps[i]);
      i_tss_host.xfer(16'h0000, 16, 8, rd);
      check("temp word", temps[i], rd);
    end
    i_tss_host.xfer(16'h0000, 4, 0, rd);
    check("partial read", 16'hE000, rd);
    fork
      i_tss_host.xfer(16'h0000, 16, 16, rd);
      begin
        repeat (40) @(posedge ref_clk);
        convert(16'h3E83);
      end
    join
    check("frozen word", 16'hEC03, rd);
    i_tss_host.xfer(16'h3CFF, 16, 16, rd);
    check("deferred word", 16'h3E83, rd);
    mode_is(1'b1);
    i_tss_host.xfer(16'h00FF, 16, 16, rd);
    check("id word", id_word, rd);
    check("maker field", {11'h000, MAKER_ID_DEF}, {11'h000, rd[15:11]});
    mode_is(1'b1);
    i_tss_host.xfer(16'hFF00, 16, 16, rd);
    check("id again", id_word, rd);
    mode_is(1'b0);
    i_tss_host.xfer(16'h00FF, 16, 8, rd);
    check("temp resumed", 16'h3E83, rd);
    mode_is(1'b1);
    // Two cut writes leave 00 in the input register; neither may be decoded
    i_tss_host.xfer(16'h0000, 16, 4, rd);
    check("id cut frame", id_word, rd);
    i_tss_host.xfer(16'h0000, 16, 4, rd);
    mode_is(1'b1);
    i_tss_host.xfer(16'h0000, 16, 8, rd);
    check("id before resume", id_word, rd);
    mode_is(1'b0);
    i_tss_host.xfer(16'h00FF, 16, 16, rd);
    check("temp kept", 16'h3E83, rd);
    mode_is(1'b1);
    // Reset in mid-run from shutdown, with select high
    reset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    mode_is(1'b0);
    i_tss_host.xfer(16'h0000, 16, 8, rd);
    check("reset again", 16'h0003, rd);
    convert(16'hF383);
    i_tss_host.xfer(16'h0000, 16, 16, rd);
    check("temp negative", 16'hF383, rd);
    print_verdict();
  end
endmodule : test_tss_top
